// [src/eepw_slave.sv]
// Two-wire slave front end of a 2048-byte nonvolatile memory.
// Assumes a synchronous array: read data valid the cycle after MEM_RD_O.
`timescale 1ns/1ps
module eepw_slave import eepw_pkg::*; #(
  parameter int unsigned PROG_CYC = `EEPW_PROG_CYC
) (
  input wire logic CORE_CLK_I,        // Core clock, 200 MHz
  input wire logic RST_B_I,           // Asynchronous reset, active low
  input wire logic SCL_I,             // Serial clock line level
  input wire logic SDA_I,             // Serial data line level
  output logic SDA_O,                 // Level driven when enabled, low
  output logic SDA_OE_O,              // High while pulling SDA low
  input wire logic WP_I,              // Write protect, high protects
  input wire logic SUPPLY_LOW_I,      // Supply below reset threshold
  input wire logic RESET_ACTIVE_I,    // A reset output is active
  output eepw_addr_t MEM_ADDR_O,      // Array address
  output logic MEM_RD_O,              // Array read strobe
  input wire logic [7:0] MEM_RDATA_I, // Array read data
  output logic MEM_WR_O,              // Array program strobe
  output logic [7:0] MEM_WDATA_O,     // Array program data
  output logic BUSY_O                 // Programming cycle running
);
  // ****************************************
  // Reset release and input synchronisers
  // ****************************************
  logic [1:0] rst_q;
  wire rst_n = rst_q[1];
  logic [2:0] st_meta;
  logic [2:0] st_sync;

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      st_meta <= 3'h0;
      st_sync <= 3'h0;
    end else begin
      st_meta <= {WP_I, SUPPLY_LOW_I, RESET_ACTIVE_I};
      st_sync <= st_meta;
    end
  end

  wire wp_s = st_sync[2];
  // Supply lockout and reset both shut the array off the bus
  wire no_access = st_sync[1] || st_sync[0];

  eepw_line_if ln ();

  eepw_line_filter u_filter (
    .clk_i(CORE_CLK_I),
    .rst_n_i(rst_n),
    .scl_i(SCL_I),
    .sda_i(SDA_I),
    .ln(ln)
  );

  // ****************************************
  // State and decode
  // ****************************************
  eepw_state_t state;
  eepw_state_t nxt;
  logic [3:0] bit_cnt;
  logic [7:0] rx;
  logic [7:0] tx;
  logic ack_phase;
  logic ack_drv;
  logic rd_pend;
  eepw_addr_t addr;
  logic [7:0] page [`EEPW_PAGE_BYTES];
  logic [15:0] page_vld;
  logic busy;
  logic [4:0] prog_idx;
  logic [31:0] timer;
  logic sda_oe;
  logic sda_lvl;

  wire [7:0] rx_byte = {rx[6:0], ln.sda};
  wire rx_state = state == ST_ADDR || state == ST_WORD
    || state == ST_DATA;
  wire byte_done = ln.scl_rise && !ack_phase && rx_state
    && bit_cnt == `EEPW_LAST_BIT;
  wire type_ok = rx_byte[7:4] == `EEPW_DEV_TYPE;
  wire addr_ok = type_ok && !busy && !no_access;
  wire wr_ok = !wp_s && !no_access;
  wire addr_hit = byte_done && state == ST_ADDR && addr_ok;
  wire wr_store = byte_done && state == ST_DATA && wr_ok;
  wire rd_ack = state == ST_READ && ln.scl_rise
    && bit_cnt == `EEPW_ACK_BIT;
  wire rd_now = (addr_hit && rx_byte[0]) || (rd_ack && !ln.sda);
  wire [10:0] rd_addr = (state == ST_ADDR)
    ? {rx_byte[3:1], addr[7:0]} : addr;
  // Only the in-page bits count, so the page wraps
  wire [10:0] wr_next = {addr[10:4], addr[3:0] + 4'h1};
  wire ack_end = ln.scl_fall && ack_phase && ack_drv;
  wire tx_step = (ack_end && nxt == ST_READ) || (ln.scl_fall
    && state == ST_READ && !ack_phase && bit_cnt != `EEPW_ACK_BIT);
  // A STOP only programs if data was accepted and nothing forbids it
  wire prog_go = ln.stop && state == ST_DATA && |page_vld
    && wr_ok && !busy;
  wire prog_done = busy && timer == PROG_CYC - 1;
  wire prog_wr = busy && !prog_idx[4] && page_vld[prog_idx[3:0]]
    && !no_access;

  // ****************************************
  // Transfer sequencing
  // ****************************************
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      nxt <= ST_IDLE;
      bit_cnt <= 4'h0;
      ack_phase <= 1'b0;
      ack_drv <= 1'b0;
    end else if (ln.stop) begin
      state <= ST_IDLE;
      ack_phase <= 1'b0;
      ack_drv <= 1'b0;
    end else if (ln.start) begin
      // Deaf while programming or held in reset
      state <= (busy || no_access) ? ST_IGNORE : ST_ADDR;
      bit_cnt <= 4'h0;
      ack_phase <= 1'b0;
      ack_drv <= 1'b0;
    end else if (no_access && state != ST_IDLE) begin
      state <= ST_IGNORE;
      ack_phase <= 1'b0;
      ack_drv <= 1'b0;
    end else if (byte_done) begin
      bit_cnt <= 4'h0;
      unique case (state)
        ST_ADDR: begin
          ack_phase <= addr_ok;
          nxt <= rx_byte[0] ? ST_READ : ST_WORD;
          if (!addr_ok) begin
            state <= ST_IGNORE;
          end
        end
        ST_WORD: begin
          ack_phase <= 1'b1;
          nxt <= ST_DATA;
        end
        default: begin
          // Protected data byte is refused
          ack_phase <= wr_ok;
          nxt <= ST_DATA;
          if (!wr_ok) begin
            state <= ST_IGNORE;
          end
        end
      endcase
    end else if (ln.scl_fall && ack_phase) begin
      ack_drv <= 1'b1;
      if (ack_drv) begin
        ack_phase <= 1'b0;
        ack_drv <= 1'b0;
        state <= nxt;
      end
    end else if (ln.scl_rise && !ack_phase
      && (rx_state || state == ST_READ)) begin
      bit_cnt <= bit_cnt + 4'h1;
      if (rd_ack) begin
        // Master ack keeps data coming, no ack ends it
        bit_cnt <= 4'h0;
        state <= ln.sda ? ST_IGNORE : ST_READ;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rx <= 8'h00;
    end else if (ln.scl_rise && rx_state) begin
      rx <= rx_byte;
    end
  end

  // ****************************************
  // Address pointer and page buffer
  // ****************************************
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      addr <= 11'h000;
    end else if (rd_now) begin
      addr <= rd_addr + 11'h001;
    end else if (addr_hit) begin
      addr[10:8] <= rx_byte[3:1];
    end else if (byte_done && state == ST_WORD) begin
      addr[7:0] <= rx_byte;
    end else if (wr_store) begin
      addr <= wr_next;
    end
  end

  // Buffer content needs no reset; page_vld says what is meaningful
  always_ff @(posedge CORE_CLK_I) begin
    if (wr_store) begin
      page[addr[3:0]] <= rx_byte;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      page_vld <= 16'h0000;
    end else if (byte_done && state == ST_WORD) begin
      page_vld <= 16'h0000;
    end else if (wr_store) begin
      page_vld[addr[3:0]] <= 1'b1;
    end
  end

  // ****************************************
  // Programming cycle
  // ****************************************
  // Buffered bytes go out first, while the timer covers the full cycle
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      prog_idx <= 5'h00;
      timer <= 32'h0;
    end else if (prog_go) begin
      busy <= 1'b1;
      prog_idx <= 5'h00;
      timer <= 32'h0;
    end else if (busy) begin
      timer <= timer + 32'h1;
      if (!prog_idx[4]) begin
        prog_idx <= prog_idx + 5'h01;
      end
      if (prog_done) begin
        busy <= 1'b0;
      end
    end
  end

  // ****************************************
  // Array port
  // ****************************************
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      MEM_ADDR_O <= 11'h000;
      MEM_RD_O <= 1'b0;
      MEM_WR_O <= 1'b0;
      MEM_WDATA_O <= 8'h00;
      rd_pend <= 1'b0;
    end else begin
      MEM_RD_O <= rd_now;
      MEM_WR_O <= prog_wr;
      rd_pend <= MEM_RD_O;
      if (prog_wr) begin
        MEM_ADDR_O <= {addr[10:4], prog_idx[3:0]};
        MEM_WDATA_O <= page[prog_idx[3:0]];
      end else if (rd_now) begin
        MEM_ADDR_O <= rd_addr;
      end
    end
  end

  // ****************************************
  // Data line driver
  // ****************************************
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      tx <= 8'h00;
    end else if (rd_pend) begin
      tx <= MEM_RDATA_I;
    end else if (tx_step) begin
      tx <= {tx[6:0], 1'b0};
    end
  end

  // Every change except the no_access release follows a falling SCL, so SDA is stable while high
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe <= 1'b0;
      sda_lvl <= 1'b0;
    end else if (no_access) begin
      sda_oe <= 1'b0;
    end else if (tx_step) begin
      sda_oe <= !tx[7];
    end else if (ln.scl_fall && ack_phase) begin
      sda_oe <= !ack_drv;
    end else if (ln.scl_fall && state == ST_READ) begin
      sda_oe <= 1'b0;
    end
  end

  assign SDA_O = sda_lvl;
  assign SDA_OE_O = sda_oe;
  assign BUSY_O = busy;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!rst_n);

  sequence s_addr_match;
    state == ST_ADDR && byte_done && addr_ok;
  endsequence

  sequence s_ack_driven;
    SDA_OE_O && ack_phase && ack_drv;
  endsequence

  a_wp_blocks: assert property (
    (ln.stop && wp_s && !busy) |=> !busy)
    else $error("programming started while write protected");

  a_lock_no_write: assert property (
    no_access |=> !MEM_WR_O)
    else $error("array written during supply lockout");

  a_reset_quiet: assert property (
    no_access |=> !SDA_OE_O)
    else $error("SDA driven while reset is active");

  a_idle_quiet: assert property (
    (state == ST_IDLE && !$past(ln.scl_fall)) |-> !SDA_OE_O)
    else $error("SDA driven before a START");

  a_stop_idle: assert property (
    ln.stop |=> state == ST_IDLE)
    else $error("STOP did not return to idle");

  a_sda_stable: assert property (
    ($changed(SDA_OE_O) && !$past(no_access)) |-> $past(ln.scl_fall))
    else $error("SDA changed away from a falling SCL");

  a_type_check: assert property (
    (state == ST_ADDR && byte_done && !type_ok) |=> state == ST_IGNORE)
    else $error("foreign address byte not ignored");

  a_addr_ack: assert property (
    s_addr_match |=> ##[0:1000] s_ack_driven)
    else $error("matching address byte not acknowledged");

  a_wp_nack: assert property (
    (state == ST_DATA && byte_done && wp_s)
    |=> !ack_phase && state == ST_IGNORE)
    else $error("protected data byte acknowledged");

  a_page_wrap: assert property (
    wr_store |=> addr[3:0] == $past(addr[3:0]) + 4'h1
      && addr[10:4] == $past(addr[10:4]))
    else $error("write pointer left its page");

  a_busy_deaf: assert property (
    busy |-> !SDA_OE_O)
    else $error("SDA driven during programming");

  a_rd_nack: assert property (
    (rd_ack && ln.sda && !ln.stop && !ln.start && !no_access)
    |=> state == ST_IGNORE)
    else $error("read went on after missing acknowledge");

  a_prog_bound: assert property (
    busy |-> timer < PROG_CYC)
    else $error("programming cycle overran its time");
endmodule

// [src/eepw_defines.svh]
// Constants of the two-wire memory slave front end.
// Assumes a 200 MHz core clock; included by the package, the modules use its macros.
`ifndef EEPW_DEFINES_SVH
`define EEPW_DEFINES_SVH

// ****************************************
// Timing
// ****************************************
`define EEPW_CLK_MHZ 200
`define EEPW_PROG_MS 10
// Longest time; whole ms and MHz make the cycle count exact, no rounding
`define EEPW_PROG_CYC (`EEPW_PROG_MS * `EEPW_CLK_MHZ * 1000)

// ****************************************
// Bus and array layout
// ****************************************
`define EEPW_DEV_TYPE 4'hA
`define EEPW_LAST_BIT 4'h7
`define EEPW_ACK_BIT 4'h8
`define EEPW_ADDR_W 11
`define EEPW_PAGE_BYTES 16
`define EEPW_IDLE_LINES 2'h3

`endif

// [src/eepw_pkg.sv]
// Types shared by the two-wire memory slave front end.
// Assumes eepw_defines.svh is on the include path.
package eepw_pkg;
  `include "eepw_defines.svh"

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_WORD = 3'b010,
    ST_DATA = 3'b011,
    ST_READ = 3'b100,
    ST_IGNORE = 3'b101
  } eepw_state_t;

  typedef logic [`EEPW_ADDR_W-1:0] eepw_addr_t;
endpackage

// [src/eepw_line_if.sv]
// Filtered bus lines and their events, from the line filter to the core.
// Assumes all members are driven on the core clock.
`timescale 1ns/1ps
interface eepw_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;

  modport filt (output scl, sda, scl_rise, scl_fall, start, stop);
  modport core (input scl, sda, scl_rise, scl_fall, start, stop);
endinterface

// [src/eepw_line_filter.sv]
// Synchroniser, glitch filter and event decoder for SCL and SDA.
// Assumes raw pin levels from outside the core clock domain.
`timescale 1ns/1ps
module eepw_line_filter import eepw_pkg::*; (
  input wire logic clk_i,   // Core clock
  input wire logic rst_n_i, // Synchronised reset, active low
  input wire logic scl_i,   // Raw clock line
  input wire logic sda_i,   // Raw data line
  eepw_line_if.filt ln      // Filtered levels and events
);
  // Bit 1 is SCL, bit 0 is SDA
  logic [1:0] meta;
  logic [1:0] sync;
  logic [1:0] hist;
  logic [1:0] filt;
  logic [1:0] filt_d;
  wire [1:0] next_filt;

  // ****************************************
  // Filter
  // ****************************************
  // Majority of three: a one-sample spike never reaches filt
  assign next_filt = (sync & hist) | (filt & (sync | hist));

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= `EEPW_IDLE_LINES;
      sync <= `EEPW_IDLE_LINES;
      hist <= `EEPW_IDLE_LINES;
      filt <= `EEPW_IDLE_LINES;
      filt_d <= `EEPW_IDLE_LINES;
    end else begin
      meta <= {scl_i, sda_i};
      sync <= meta;
      hist <= sync;
      filt <= next_filt;
      filt_d <= filt;
    end
  end

  // ****************************************
  // Events
  // ****************************************
  assign ln.scl = filt[1];
  assign ln.sda = filt[0];
  assign ln.scl_rise = filt[1] && !filt_d[1];
  assign ln.scl_fall = !filt[1] && filt_d[1];
  assign ln.start = filt[1] && filt_d[1] && !filt[0] && filt_d[0];
  assign ln.stop = filt[1] && filt_d[1] && filt[0] && !filt_d[0];
endmodule

// [tb/eepw_mst.sv]
// Bus master model that drives SCL and SDA toward the memory slave.
// Assumes the bench resolves SDA as an open-drain wire with a pull-up.
`timescale 1ns/1ps
module eepw_mst (
  output logic scl_o,     // Serial clock line
  output logic sda_low_o, // High while pulling SDA low
  input wire logic sda_i  // Resolved SDA level
);
  // ****************************************
  // Both lines released between frames
  // ****************************************
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // Low 32 ns, high 16 ns: the slave turns SDA about 25 ns after a fall
  task automatic clk_bit(input logic b, output logic seen);
    #4;
    sda_low_o = ~b; // Moves only while SCL is low
    #28;
    scl_o = 1'b1; // Master owns the clock
    #8;
    seen = sda_i;
    #8;
    scl_o = 1'b0;
  endtask

  // From an idle bus or as a repeated start only
  task automatic start_cond();
    #4;
    sda_low_o = 1'b0;
    #28;
    scl_o = 1'b1;
    #24;
    sda_low_o = 1'b1; // Falls while SCL is high
    #24;
    scl_o = 1'b0;
  endtask

  task automatic stop_cond();
    #4;
    sda_low_o = 1'b1;
    #28;
    scl_o = 1'b1;
    #24;
    sda_low_o = 1'b0; // Rises while SCL is high
    #48;
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
    end
    clk_bit(1'b1, ack_n); // Released for the slave's answer
  endtask

  task automatic recv_byte(input logic ack_n, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, d[i]);
    end
    clk_bit(ack_n, s); // Low asks for one more byte
  endtask

  // Pulse far shorter than the filter window
  task automatic glitch();
    sda_low_o = 1'b1;
    #3;
    sda_low_o = 1'b0;
    #20;
  endtask
endmodule

// [tb/eepw_slave_tb_top.sv]
// Self-checking bench for the two-wire memory slave front end.
// Assumes the master model and a synchronous array model held here.
`timescale 1ns/1ps
module eepw_slave_tb_top;
  localparam int unsigned PROG = 600;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wp = 1'b0;
  logic sup_low = 1'b0;
  logic rst_act = 1'b0;
  logic m_scl, m_low, sda_o, sda_oe, rd, wr, busy, rd_q;
  logic [7:0] wdata;
  logic [7:0] rdata = 8'h00;
  logic [7:0] mem [0:2047];
  eepw_pkg::eepw_addr_t addr;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int wr_count = 0;
  wire sda = ~(m_low | (sda_oe & ~sda_o));

  eepw_slave #(.PROG_CYC(PROG)) eepw_slave_i (
    .CORE_CLK_I(clk), .RST_B_I(rst_b), .SCL_I(m_scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE_O(sda_oe), .WP_I(wp), .SUPPLY_LOW_I(sup_low),
    .RESET_ACTIVE_I(rst_act), .MEM_ADDR_O(addr), .MEM_RD_O(rd),
    .MEM_RDATA_I(rdata), .MEM_WR_O(wr), .MEM_WDATA_O(wdata),
    .BUSY_O(busy));
  eepw_mst eepw_mst_i (.scl_o(m_scl), .sda_low_o(m_low), .sda_i(sda));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // ****************************************
  // Array model and run limit
  // ****************************************
  always @(posedge clk) begin
    cycles <= cycles + 1;
    rd_q <= rd;
    if (wr) begin
      mem[addr] <= wdata;
      wr_count <= wr_count + 1;
    end
    if (rd)
      rdata <= mem[addr];
    else if (!rd_q)
      rdata <= ~rdata; // Stale data must never pass for a read
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk_bit(input string what, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic chk_byte(input string what, input logic [7:0] e,
                          input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic send(input logic [7:0] d, input logic ack_n);
    logic a;
    eepw_mst_i.send_byte(d, a);
    chk_bit($sformatf("ack of %h", d), ack_n, a);
  endtask

  task automatic wait_prog(input int t0);
    for (int n = 0; n < 2 * PROG && busy !== 1'b0; n++) @(negedge clk);
    chk_bit("busy end", 1'b0, busy);
    chk_bit("program time", 1'b1, cycles - t0 <= PROG);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_byte_write();
    int t0;
    int w0;
    w0 = wr_count;
    eepw_mst_i.start_cond();
    send(8'hA2, 1'b0);
    send(8'h34, 1'b0);
    send(8'hC5, 1'b0);
    eepw_mst_i.stop_cond();
    t0 = cycles;
    @(negedge clk);
    chk_bit("busy", 1'b1, busy);
    eepw_mst_i.start_cond();
    send(8'hA2, 1'b1);
    eepw_mst_i.stop_cond();
    eepw_mst_i.start_cond();
    send(8'hA3, 1'b1);
    eepw_mst_i.stop_cond();
    wait_prog(t0);
    chk_byte("mem 134", 8'hC5, mem[11'h134]);
    chk_byte("writes", 8'h01, 8'(wr_count - w0));
    eepw_mst_i.start_cond();
    send(8'hA2, 1'b0);
    eepw_mst_i.stop_cond();
  endtask

  task automatic t_page();
    logic [7:0] exp [16];
    int w0;
    w0 = wr_count;
    eepw_mst_i.start_cond();
    send(8'hAA, 1'b0);
    send(8'h37, 1'b0);
    for (int k = 0; k < 18; k++) begin
      send(8'h80 + k[7:0], 1'b0);
      exp[(k + 7) % 16] = 8'h80 + k[7:0];
    end
    eepw_mst_i.stop_cond();
    wait_prog(cycles);
    for (int j = 0; j < 16; j++) begin
      chk_byte("page byte", exp[j], mem[11'h530 + j]);
    end
    chk_byte("next page", 8'h1A, mem[11'h540]);
    chk_byte("writes", 8'h10, 8'(wr_count - w0));
  endtask

  task automatic t_read();
    logic [7:0] d;
    eepw_mst_i.start_cond();
    send(8'hAE, 1'b0);
    send(8'hFE, 1'b0);
    eepw_mst_i.start_cond();
    send(8'hAF, 1'b0);
    eepw_mst_i.recv_byte(1'b0, d);
    chk_byte("read 7FE", 8'hA4, d);
    eepw_mst_i.recv_byte(1'b0, d);
    chk_byte("read 7FF", 8'hA5, d);
    eepw_mst_i.recv_byte(1'b1, d);
    chk_byte("read 000", 8'h5A, d);
    #40;
    chk_bit("released", 1'b0, sda_oe);
    eepw_mst_i.stop_cond();
  endtask

  task automatic t_refuse();
    logic [7:0] bad [3] = '{8'h50, 8'hB0, 8'h2E};
    foreach (bad[j]) begin
      eepw_mst_i.start_cond();
      send(bad[j], 1'b1);
      send(8'h00, 1'b1);
      eepw_mst_i.stop_cond();
    end
    eepw_mst_i.glitch();
    send(8'hA0, 1'b1);
    eepw_mst_i.stop_cond();
  endtask

  task automatic t_protect();
    int w0;
    w0 = wr_count;
    @(negedge clk);
    wp = 1'b1;
    repeat (4) @(negedge clk);
    eepw_mst_i.start_cond();
    send(8'hA4, 1'b0);
    send(8'h10, 1'b0);
    send(8'h99, 1'b1);
    eepw_mst_i.stop_cond();
    repeat (20) @(negedge clk);
    chk_bit("busy", 1'b0, busy);
    chk_byte("writes", 8'h00, 8'(wr_count - w0));
    chk_byte("mem 410", 8'h4A, mem[11'h410]);
    wp = 1'b0;
  endtask

  task automatic t_lockout();
    int w0;
    for (int j = 0; j < 2; j++) begin
      w0 = wr_count;
      @(negedge clk);
      sup_low = (j == 0);
      rst_act = (j == 1);
      repeat (4) @(negedge clk);
      eepw_mst_i.start_cond();
      send(8'hA6, 1'b1);
      send(8'h20, 1'b1);
      eepw_mst_i.stop_cond();
      repeat (20) @(negedge clk);
      chk_bit("busy", 1'b0, busy);
      chk_byte("writes", 8'h00, 8'(wr_count - w0));
    end
    sup_low = 1'b0;
    rst_act = 1'b0;
  endtask

  initial begin
    for (int i = 0; i < 2048; i++) mem[i] = i[7:0] ^ 8'h5A;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    repeat (8) @(negedge clk);
    t_byte_write();
    t_page();
    t_read();
    t_refuse();
    t_protect();
    t_lockout();
    print_verdict();
  end
endmodule
